// file: pkg/qdc_pkg.sv
// package: command codes, field positions and reset values of the quad dac command port
package qdc_pkg;
    localparam int unsigned QDC_WORD_BITS = 16;
    localparam int unsigned QDC_CODE_BITS = 10;
    localparam int unsigned QDC_CHANS = 4;
    // field positions inside the command word
    localparam int unsigned QDC_ADDR_MSB = 15;
    localparam int unsigned QDC_ADDR_LSB = 14;
    localparam int unsigned QDC_CTRL_MSB = 13;
    localparam int unsigned QDC_CTRL_LSB = 12;
    localparam int unsigned QDC_CODE_MSB = 11;
    localparam int unsigned QDC_CODE_LSB = 2;
    // address/control opcode: {chan_addr_hi, chan_addr_lo, ctrl_hi, ctrl_lo}
    localparam logic [3:0] QDC_OP_NOP = 4'h0;
    localparam logic [3:0] QDC_OP_UPO_LOW = 4'h2;
    localparam logic [3:0] QDC_OP_UPDATE_ALL = 4'h4;
    localparam logic [3:0] QDC_OP_UPO_HIGH = 4'h6;
    localparam logic [3:0] QDC_OP_LOAD_ALL = 4'h8;
    localparam logic [3:0] QDC_OP_MODE0 = 4'hA;
    localparam logic [3:0] QDC_OP_SHUTDOWN = 4'hC;
    localparam logic [3:0] QDC_OP_MODE1 = 4'hE;
    localparam logic [1:0] QDC_CTRL_LOAD_IN = 2'h1;
    localparam logic [1:0] QDC_CTRL_LOAD_UPD = 2'h3;
    // reset values
    localparam logic [9:0] QDC_CODE_RST = 10'h000;
    localparam logic QDC_MODE_RST = 1'b0;
    localparam logic QDC_UPO_RST = 1'b0;
    // link timing
    localparam int unsigned QDC_SYNC_STAGES = 2;
endpackage

// file: pkg/qdc_cmd_if.sv
// interface: received command word and valid strobe from the serial front end to the register bank
`timescale 1ns/1ns
interface qdc_cmd_if;
    logic valid;
    logic [15:0] word;
    modport src (output valid, output word);
    modport dst (input valid, input word);
endinterface

// file: hw/qdc_sync.sv
// module: two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module qdc_sync #(
    parameter int unsigned WIDTH = 1,
    // idle level of each pin, so that reset release shows no false edge
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // async in, synced out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// file: hw/qdc_front.sv
// module: serial shifter, frame detect and serial data output timing
`timescale 1ns/1ns
module qdc_front
    import qdc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // synchronised link pins
    input wire logic sclk_s,
    input wire logic cs_n_s,
    input wire logic din_s,
    // control
    input wire logic clear_n_s,
    input wire logic out_mode,
    // serial data output
    output logic dout,
    // command to register bank
    qdc_cmd_if.src cmd
);
    logic sclk_q;
    logic cs_n_q;
    logic [15:0] shift_q;
    logic [3:0] cnt_q;
    logic full_q;
    logic out_bit_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;

    assign sclk_rise = sclk_s & ~sclk_q;
    assign sclk_fall = ~sclk_s & sclk_q;
    assign cs_rise = cs_n_s & ~cs_n_q;

    // edge history of link pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
        end
    end

    // shift din on rising sclk only while selected
    always_ff @(posedge clk) begin
        if (rst || !clear_n_s) begin
            shift_q <= 16'h0000;
        end else if (!cs_n_s && sclk_rise) begin
            shift_q <= {shift_q[14:0], din_s};
        end
    end

    // bit pushed out of the msb end by each rising sclk, the seventeenth stage
    always_ff @(posedge clk) begin
        if (rst || !clear_n_s) begin
            out_bit_q <= 1'b0;
        end else if (!cs_n_s && sclk_rise) begin
            out_bit_q <= shift_q[15];
        end
    end

    // count bits so that only whole words are decoded
    always_ff @(posedge clk) begin
        if (rst || cs_n_s) begin
            cnt_q <= 4'h0;
            full_q <= 1'b0;
        end else if (sclk_rise) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hF) begin
                full_q <= 1'b1;
            end
        end
    end

    // word handed over on chip select rising edge
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd.valid <= 1'b0;
            cmd.word <= 16'h0000;
        end else begin
            cmd.valid <= cs_rise && full_q && clear_n_s;
            if (cs_rise) begin
                cmd.word <= shift_q;
            end
        end
    end

    // dout follows the shift register msb on the chosen sclk edge
    always_ff @(posedge clk) begin
        if (rst || !clear_n_s) begin
            dout <= 1'b0;
        end else if (!cs_n_s) begin
            if (out_mode ? sclk_rise : sclk_fall) begin
                // mode 1 lags 16 cycles, mode 0 gives the pushed-out bit half a cycle later
                dout <= out_mode ? shift_q[15] : out_bit_q;
            end
        end
    end
endmodule

// file: hw/qdc_top.sv
// module: quad dac serial command port, input and dac register bank
`timescale 1ns/1ns
module qdc_top
    import qdc_pkg::*;
#(
    parameter int unsigned CODE_BITS = QDC_CODE_BITS,
    parameter int unsigned CHANS = QDC_CHANS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // control pins
    input wire logic clear_n,
    input wire logic shutdown_lockout_n,
    output logic user_logic_out,
    // status
    output logic shutdown,
    output logic out_mode,
    // dac and input register contents, channel 0 in the low bits
    output logic [qdc_pkg::QDC_CHANS*qdc_pkg::QDC_CODE_BITS-1:0] dac_code,
    output logic [qdc_pkg::QDC_CHANS*qdc_pkg::QDC_CODE_BITS-1:0] input_code
);
    import qdc_pkg::*;

    // the command decode is fixed to the word layout, refuse other sizes at elaboration
    if (CODE_BITS != QDC_CODE_BITS || CHANS != QDC_CHANS) begin : g_bad_size
        $error("qdc_top: only 10-bit codes and four channels are supported");
    end

    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic clear_n_s;
    logic lock_n_s;
    logic lock_n_q;
    logic lock_fall;
    qdc_cmd_if cmd_bus ();

    // bring all pin inputs into the clock domain
    // reset values are the idle pin levels: sclk low, cs_n high, din low, clear_n high, lockout high
    qdc_sync #(.WIDTH(5), .RST_VAL(5'b0_1011)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({sclk, cs_n, din, clear_n, shutdown_lockout_n}),
        .sync_out({sclk_s, cs_n_s, din_s, clear_n_s, lock_n_s})
    );

    // serial front end
    qdc_front u_front (
        .clk(clk),
        .rst(rst),
        .sclk_s(sclk_s),
        .cs_n_s(cs_n_s),
        .din_s(din_s),
        .clear_n_s(clear_n_s),
        .out_mode(out_mode),
        .dout(dout),
        .cmd(cmd_bus.src)
    );

    // command fields
    logic [3:0] op;
    logic [1:0] addr;
    logic [1:0] ctrl;
    logic [9:0] code;
    logic load_in;
    logic update_all;
    logic load_all;
    logic go_down;
    logic wake;

    assign addr = cmd_bus.word[QDC_ADDR_MSB:QDC_ADDR_LSB];
    assign ctrl = cmd_bus.word[QDC_CTRL_MSB:QDC_CTRL_LSB];
    assign op = {addr, ctrl};
    assign code = cmd_bus.word[QDC_CODE_MSB:QDC_CODE_LSB];

    // decode strobes, all but lock_fall qualified by the cs rising edge pulse
    assign load_in = cmd_bus.valid && (ctrl == QDC_CTRL_LOAD_IN || ctrl == QDC_CTRL_LOAD_UPD);
    assign load_all = cmd_bus.valid && op == QDC_OP_LOAD_ALL;
    assign update_all = cmd_bus.valid && (ctrl == QDC_CTRL_LOAD_UPD || op == QDC_OP_UPDATE_ALL
        || op == QDC_OP_MODE0 || op == QDC_OP_MODE1);
    assign go_down = cmd_bus.valid && op == QDC_OP_SHUTDOWN && lock_n_s;
    assign lock_fall = lock_n_q & ~lock_n_s;
    assign wake = cmd_bus.valid && (op == QDC_OP_UPDATE_ALL || op == QDC_OP_LOAD_ALL);

    // lockout edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_n_q <= 1'b1;
        end else begin
            lock_n_q <= lock_n_s;
        end
    end

    // per channel input and dac registers
    logic [9:0] in_q [QDC_CHANS];
    logic [9:0] dac_q [QDC_CHANS];
    genvar g;
    generate
        for (g = 0; g < QDC_CHANS; g++) begin : g_chan
            // input register: single load or broadcast load, kept in shutdown
            always_ff @(posedge clk) begin
                if (rst || !clear_n_s) begin
                    in_q[g] <= QDC_CODE_RST;
                end else if (load_all) begin
                    in_q[g] <= code;
                end else if (load_in && addr == 2'(g)) begin
                    in_q[g] <= code;
                end
            end
            // dac register: broadcast load or copy from input register
            always_ff @(posedge clk) begin
                if (rst || !clear_n_s) begin
                    dac_q[g] <= QDC_CODE_RST;
                end else if (load_all) begin
                    dac_q[g] <= code;
                end else if (update_all) begin
                    // a load-and-update takes the new code in the same step
                    dac_q[g] <= (load_in && addr == 2'(g)) ? code : in_q[g];
                end
            end
            assign dac_code[g*10 +: 10] = dac_q[g];
            assign input_code[g*10 +: 10] = in_q[g];
        end
    endgenerate

    // shutdown flag; a falling lockout, an update all or a load all wakes the device
    always_ff @(posedge clk) begin
        if (rst || !clear_n_s) begin
            shutdown <= 1'b0;
        end else if (lock_fall || wake) begin
            shutdown <= 1'b0;
        end else if (go_down) begin
            shutdown <= 1'b1;
        end
    end

    // serial output edge mode
    always_ff @(posedge clk) begin
        if (rst) begin
            out_mode <= QDC_MODE_RST;
        end else if (cmd_bus.valid && op == QDC_OP_MODE1) begin
            out_mode <= 1'b1;
        end else if (cmd_bus.valid && op == QDC_OP_MODE0) begin
            out_mode <= 1'b0;
        end
    end

    // user logic output
    always_ff @(posedge clk) begin
        if (rst || !clear_n_s) begin
            user_logic_out <= QDC_UPO_RST;
        end else if (cmd_bus.valid && op == QDC_OP_UPO_HIGH) begin
            user_logic_out <= 1'b1;
        end else if (cmd_bus.valid && op == QDC_OP_UPO_LOW) begin
            user_logic_out <= 1'b0;
        end
    end

    // assertions
    property p_nop_keeps;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && op == QDC_OP_NOP && clear_n_s) |=> $stable(dac_code) && $stable(input_code);
    endproperty
    a_nop_keeps: assert property (p_nop_keeps) else $error("nop changed a register");

    property p_load_in_only;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && ctrl == QDC_CTRL_LOAD_IN && clear_n_s) |=> $stable(dac_code)
            && input_code[addr*10 +: 10] == $past(code);
    endproperty
    a_load_in_only: assert property (p_load_in_only) else $error("input load wrong");

    property p_load_upd;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && ctrl == QDC_CTRL_LOAD_UPD && clear_n_s) |=> dac_code == input_code;
    endproperty
    a_load_upd: assert property (p_load_upd) else $error("load and update mismatch");

    property p_update_all;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && op == QDC_OP_UPDATE_ALL && clear_n_s) |=> dac_code == input_code && !shutdown;
    endproperty
    a_update_all: assert property (p_update_all) else $error("update all failed");

    property p_load_all;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && op == QDC_OP_LOAD_ALL && clear_n_s) |=>
            dac_code == {4{$past(code)}} && input_code == {4{$past(code)}} && !shutdown;
    endproperty
    a_load_all: assert property (p_load_all) else $error("broadcast load failed");

    property p_lockout;
        @(posedge clk) disable iff (rst)
        (!shutdown && !lock_n_s && !lock_n_q) |=> !shutdown;
    endproperty
    a_lockout: assert property (p_lockout) else $error("shutdown despite lockout");

    property p_upo;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && clear_n_s && op == QDC_OP_UPO_HIGH) |=> user_logic_out ##1 $stable(user_logic_out)
            || cmd_bus.valid || !clear_n_s;
    endproperty
    a_upo: assert property (p_upo) else $error("user output not set");

    property p_mode;
        @(posedge clk) disable iff (rst)
        (cmd_bus.valid && op == QDC_OP_MODE1) |=> out_mode && dac_code == input_code;
    endproperty
    a_mode: assert property (p_mode) else $error("mode 1 not taken");

    property p_clear;
        @(posedge clk) disable iff (rst)
        (!clear_n_s) |=> dac_code == '0 && input_code == '0 && !user_logic_out && !dout;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not applied");

    property p_only_on_cs;
        @(posedge clk) disable iff (rst)
        (!cmd_bus.valid && clear_n_s) |=> $stable(input_code);
    endproperty
    a_only_on_cs: assert property (p_only_on_cs) else $error("update outside cs edge");
endmodule

// file: tb/qdc_host_model.sv
// serial host model: drives link clock, chip select and data, captures echoed data
`timescale 1ns/1ns
module qdc_host_model (
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    // echo words captured before each rising and each falling link edge
    output logic [15:0] rx_rise,
    output logic [15:0] rx_fall
);
    // idle link: clock parked low, not selected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        rx_rise = 16'h0000;
        rx_fall = 16'h0000;
    end

    // select, then clock out n bits msb first; 320 ns link period
    task automatic shift(input logic [15:0] w, input int n);
        cs_n = 1'b0;
        #80;
        for (int i = 15; i > 15 - n; i--) begin
            din = w[i];
            #160;
            rx_rise = {rx_rise[14:0], dout};
            sclk = 1'b1;
            #159;
            rx_fall = {rx_fall[14:0], dout};
            #1 sclk = 1'b0;
        end
    endtask

    // deselect; released data line shows the inverse of its last bit
    task automatic finish();
        #80 cs_n = 1'b1;
        din = ~din;
        #480;
    endtask

    // one whole command word with chip select low throughout
    task automatic send(input logic [15:0] w);
        shift(w, 16);
        finish();
    endtask

    // clock and data activity while not selected
    task automatic noise();
        for (int i = 0; i < 16; i++) begin
            din = ~din;
            #160 sclk = 1'b1;
            #160 sclk = 1'b0;
        end
        #320;
    endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the quad dac command port
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clear_n = 1'b1;
    logic shutdown_lockout_n = 1'b1;
    logic sclk, cs_n, din, dout, user_logic_out, shutdown, out_mode;
    logic [39:0] dac_code, input_code, e_in, e_dac;
    logic e_upo, e_sd, e_mode;
    logic [15:0] rx_rise, rx_fall;
    int n_fail = 0;
    int num_checks = 0;

    // 25 MHz system clock
    always #20 clk = ~clk;

    qdc_top dut_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .clear_n(clear_n), .shutdown_lockout_n(shutdown_lockout_n), .user_logic_out(user_logic_out),
        .shutdown(shutdown), .out_mode(out_mode), .dac_code(dac_code), .input_code(input_code));

    qdc_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .rx_rise(rx_rise), .rx_fall(rx_fall));

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // compare every register output except dout with the expected state
    task automatic cmp(input string nm);
        chk({nm, " input"}, e_in, input_code);
        chk({nm, " dac"}, e_dac, dac_code);
        chk({nm, " upo"}, {39'h0, e_upo}, {39'h0, user_logic_out});
        chk({nm, " sd"}, {39'h0, e_sd}, {39'h0, shutdown});
        chk({nm, " mode"}, {39'h0, e_mode}, {39'h0, out_mode});
        $display("done: %s", nm);
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one command, sub-bits zero, then let the update land
    task automatic cmd(input logic [3:0] op, input logic [9:0] c);
        @(negedge clk);
        host_u.send({op, c, 2'b00});
        wt(8);
    endtask

    task automatic t_load_in();
        logic [9:0] cv [4] = '{10'h001, 10'h155, 10'h2AA, 10'h3FF};
        for (int ch = 0; ch < 3; ch++) begin
            cmd({ch[1:0], 2'b01}, cv[ch]);
            e_in[ch*10 +: 10] = cv[ch];
        end
        host_u.shift({4'hD, cv[3], 2'b00}, 16);
        wt(10);
        cmp("held_until_deselect");
        host_u.finish();
        wt(8);
        e_in[30 +: 10] = cv[3];
        cmp("load_in");
    endtask

    task automatic t_load_upd();
        cmd(4'hB, 10'h1C3);
        e_in[20 +: 10] = 10'h1C3;
        e_dac = e_in;
        cmp("load_upd");
    endtask

    task automatic t_shut();
        cmd(4'hC, 10'h000);
        e_sd = 1'b1;
        cmp("shut");
        cmd(4'h1, 10'h0F0);
        e_in[9:0] = 10'h0F0;
        cmp("shut_keep");
        cmd(4'h4, 10'h3FF);
        e_dac = e_in;
        e_sd = 1'b0;
        cmp("update_all");
    endtask

    task automatic t_lockout();
        @(negedge clk) shutdown_lockout_n = 1'b0;
        cmd(4'hC, 10'h000);
        cmp("lockout_blocks");
        @(negedge clk) shutdown_lockout_n = 1'b1;
        cmd(4'hC, 10'h000);
        e_sd = 1'b1;
        @(negedge clk) shutdown_lockout_n = 1'b0;
        wt(8);
        e_sd = 1'b0;
        cmp("lockout_wake");
        @(negedge clk) shutdown_lockout_n = 1'b1;
    endtask

    task automatic t_load_all();
        cmd(4'hC, 10'h000);
        cmd(4'h8, 10'h2D3);
        e_in = {4{10'h2D3}};
        e_dac = e_in;
        e_sd = 1'b0;
        cmp("load_all");
    endtask

    task automatic t_upo();
        cmd(4'h6, 10'h000);
        e_upo = 1'b1;
        cmp("upo_high");
        cmd(4'h0, 10'h3FF);
        cmp("no_action_cmd");
        cmd(4'h2, 10'h3FF);
        e_upo = 1'b0;
        cmp("upo_low");
    endtask

    task automatic t_mode();
        cmd(4'h5, 10'h123);
        e_in[10 +: 10] = 10'h123;
        cmd(4'hE, 10'h000);
        e_mode = 1'b1;
        e_dac = e_in;
        cmp("mode1");
        host_u.send(16'h0AB4);
        host_u.send(16'h0000);
        chk("echo_mode1", 40'h0AB4, {24'h0, rx_fall});
        cmd(4'hA, 10'h000);
        e_mode = 1'b0;
        cmp("mode0");
        host_u.send(16'h0B78);
        host_u.send(16'h0000);
        // half-cycle longer lag: sixteen rising samples see the last bit of the mode word, then 0B78 bits 15..1
        chk("echo_mode0", 40'h05BC, {24'h0, rx_rise});
    endtask

    task automatic t_reject();
        @(negedge clk);
        host_u.shift({4'h8, 10'h3FF, 2'b00}, 8);
        host_u.finish();
        wt(8);
        cmp("short_frame");
        host_u.noise();
        wt(8);
        cmp("deselected_noise");
    endtask

    task automatic t_clear();
        cmd(4'h6, 10'h000);
        @(negedge clk) clear_n = 1'b0;
        wt(6);
        e_in = '0;
        e_dac = '0;
        e_upo = 1'b0;
        cmp("clear");
        chk("clear_dout", 40'h0, {39'h0, dout});
        @(negedge clk) clear_n = 1'b1;
        wt(4);
    endtask

    // watchdog cuts a hang well beyond the expected run
    initial begin
        #2000000;
        n_fail++;
        end_of_test();
    end

    // main sequence
    initial begin
        e_in = '0;
        e_dac = '0;
        e_upo = 1'b0;
        e_sd = 1'b0;
        e_mode = 1'b0;
        wt(20);
        rst = 1'b0;
        wt(5);
        cmp("reset");
        t_load_in();
        t_load_upd();
        t_shut();
        t_lockout();
        t_load_all();
        t_upo();
        t_mode();
        t_reject();
        t_clear();
        end_of_test();
    end
endmodule
